// File: rtl/scc_ctrl.sv
// Behaviour
// - Converter clock is system clock over divisor+1
// - One of five start sources selected
// - Software writes busy one to start
// - Busy reads one during conversion, hardware clears
// - Busy falling at end of conversion sets done flag, raises interrupt
// - Result valid in data register when done
// - Timer 2 low or high overflow by mode
// - External start on rising edge of pin
// - Default mode tracks except while converting
// - Low-power mode tracks three converter clocks first
// - Low-power external: track while pin low
// - Reference select: pin when zero, supply when one
// - Bias enable bit switches bias generator
`timescale 1ns/1ns
module scc_ctrl
  import scc_pkg::*;
#(
  parameter int DIV_W = 5,
  parameter int RES_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register access
  input wire scc_pkg::scc_sfr_req_t sfr_i,
  output logic [7:0] sfr_rdata_o,
  // Start triggers
  input wire scc_pkg::scc_trig_t trig_i,
  input wire logic ext_convert_start_i,
  // Analog converter
  output logic conv_track_o,
  output logic conv_sar_clk_o,
  output logic conv_start_o,
  input wire logic conv_eoc_i,
  input wire logic [RES_W-1:0] conv_result_i,
  output logic ref_source_select_o,
  output logic temp_sensor_enable_o,
  output logic bias_gen_enable_o,
  // Completion
  output logic conv_irq_o,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output logic [RES_W-1:0] res_data_o
);
  import scc_pkg::*;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_TRACK = 2'b01,
    SCC_CONV = 2'b10
  } scc_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ref_r, ref_nxt;
  logic en_r, en_nxt, tm_r, tm_nxt, ie_r, ie_nxt;
  logic done_r, done_nxt, busy_r, busy_nxt;
  logic [2:0] src_r, src_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [RES_W-1:0] data_r, data_nxt;
  scc_state_t st_r, st_nxt;
  logic [DIV_W-1:0] pre_r, pre_nxt;
  logic [3:0] sclk_r, sclk_nxt;
  logic [2:0] ext_sync_r;
  logic ext_lvl_r, ext_lvl_nxt;
  logic ext_rise, ext_low, start_evt, sar_tick, busy_fall;
  logic wr_ctrl;

  // Converter clock count as a pure function of divisor
  function automatic logic tick_at(input logic [DIV_W-1:0] cnt,
                                   input logic [DIV_W-1:0] div);
    tick_at = (cnt == div);
  endfunction

  function automatic logic wr_hit(input scc_sfr_req_t r,
                                  input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // External start pin, three-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_convert_start_i};
    end
  end

  // Level moves only when stages two and three agree
  always_comb begin
    ext_lvl_nxt = ext_lvl_r;
    if (ext_sync_r[1] == ext_sync_r[2]) begin
      ext_lvl_nxt = ext_sync_r[2];
    end
  end

  assign ext_rise = ext_lvl_nxt && !ext_lvl_r;
  assign ext_low = !ext_lvl_r;

  // ----------------------------------------------------------------
  // Start selection
  // ----------------------------------------------------------------
  assign wr_ctrl = wr_hit(sfr_i, SCC_CTRL_ADDR);

  // Only the chosen source counts; others are dropped here
  always_comb begin
    start_evt = 1'b0;
    unique case (src_r)
      SCC_SRC_SW: start_evt = wr_ctrl && sfr_i.wdata[SCC_BUSY_BIT];
      SCC_SRC_T0: start_evt = trig_i.t0_ovf;
      SCC_SRC_T1: start_evt = trig_i.t1_ovf;
      SCC_SRC_T2: begin
        start_evt = trig_i.t2_split ? trig_i.t2_lo_ovf
                                    : trig_i.t2_hi_ovf;
      end
      SCC_SRC_EXT: start_evt = ext_rise;
      default: start_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Converter clock divider
  // ----------------------------------------------------------------
  // Prescaler free-runs while enabled so the clock has no odd first phase
  always_comb begin
    pre_nxt = pre_r + 1'b1;
    sar_tick = 1'b0;
    if (!en_r || tick_at(pre_r, div_r)) begin
      pre_nxt = '0;
      sar_tick = en_r;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sclk_nxt = sclk_r;
    busy_nxt = busy_r;
    unique case (st_r)
      SCC_IDLE: begin
        sclk_nxt = '0;
        // In low-power external mode the pin edge itself ends tracking
        if (en_r && start_evt) begin
          busy_nxt = 1'b1;
          if (tm_r && src_r != SCC_SRC_EXT) begin
            st_nxt = SCC_TRACK;
          end else begin
            st_nxt = SCC_CONV;
          end
        end
      end
      SCC_TRACK: begin
        if (sar_tick) begin
          sclk_nxt = sclk_r + 1'b1;
          if (sclk_r == 4'(SCC_TRACK_CLKS - 1)) begin
            sclk_nxt = '0;
            st_nxt = SCC_CONV;
          end
        end
      end
      SCC_CONV: begin
        // Analog side ends it; a missing eoc is bounded by a clock count
        if (sar_tick) begin
          sclk_nxt = sclk_r + 1'b1;
        end
        if (conv_eoc_i || (sar_tick &&
            sclk_r == 4'(SCC_CONV_CLKS - 1))) begin
          st_nxt = SCC_IDLE;
          busy_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = SCC_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    if (!en_r) begin
      st_nxt = SCC_IDLE;
      busy_nxt = 1'b0;
    end
  end

  // An abort by clearing enable drops busy but must not report completion
  assign busy_fall = en_r && busy_r && !busy_nxt && st_r == SCC_CONV;

  // ----------------------------------------------------------------
  // Register writes, done flag and result
  // ----------------------------------------------------------------
  always_comb begin
    ref_nxt = ref_r;
    en_nxt = en_r;
    tm_nxt = tm_r;
    ie_nxt = ie_r;
    src_nxt = src_r;
    div_nxt = div_r;
    done_nxt = done_r;
    data_nxt = data_r;
    if (wr_hit(sfr_i, SCC_REF_CTRL_ADDR)) begin
      ref_nxt = sfr_i.wdata & SCC_REF_CTRL_WMASK;
    end
    if (wr_hit(sfr_i, SCC_CFG_ADDR)) begin
      div_nxt = sfr_i.wdata[SCC_DIV_LSB +: DIV_W];
    end
    if (wr_ctrl) begin
      en_nxt = sfr_i.wdata[SCC_EN_BIT];
      tm_nxt = sfr_i.wdata[SCC_TM_BIT];
      ie_nxt = sfr_i.wdata[SCC_IE_BIT];
      src_nxt = sfr_i.wdata[SCC_SRC_LSB +: 3];
      done_nxt = sfr_i.wdata[SCC_DONE_BIT];
    end
    // Completion beats a software clear in the same cycle
    if (busy_fall) begin
      done_nxt = 1'b1;
      data_nxt = conv_result_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_r <= SCC_REF_CTRL_RST;
      en_r <= SCC_CTRL_RST[SCC_EN_BIT];
      tm_r <= SCC_CTRL_RST[SCC_TM_BIT];
      ie_r <= SCC_CTRL_RST[SCC_IE_BIT];
      src_r <= SCC_CTRL_RST[SCC_SRC_LSB +: 3];
      div_r <= SCC_CFG_RST[SCC_DIV_LSB +: DIV_W];
      done_r <= 1'b0;
      busy_r <= 1'b0;
      data_r <= '0;
      st_r <= SCC_IDLE;
      pre_r <= '0;
      sclk_r <= '0;
      ext_lvl_r <= 1'b0;
    end else begin
      ref_r <= ref_nxt;
      en_r <= en_nxt;
      tm_r <= tm_nxt;
      ie_r <= ie_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      data_r <= data_nxt;
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      sclk_r <= sclk_nxt;
      ext_lvl_r <= ext_lvl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    sfr_rdata_o = 8'h00;
    unique case (sfr_i.addr)
      SCC_REF_CTRL_ADDR: sfr_rdata_o = ref_r;
      SCC_CFG_ADDR: sfr_rdata_o = 8'({div_r, 3'h0});
      SCC_DATA_ADDR: sfr_rdata_o = 8'(data_r);
      SCC_CTRL_ADDR: begin
        sfr_rdata_o = {en_r, tm_r, done_r, busy_r, ie_r, src_r};
      end
      default: sfr_rdata_o = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  // Low-power external mode: track only while the pin is low
  always_comb begin
    conv_track_o = 1'b0;
    if (en_r && st_r != SCC_CONV) begin
      if (!tm_r) begin
        conv_track_o = 1'b1;
      end else if (src_r == SCC_SRC_EXT) begin
        conv_track_o = ext_low && st_r == SCC_IDLE;
      end else begin
        conv_track_o = (st_r == SCC_TRACK);
      end
    end
  end

  assign conv_sar_clk_o = sar_tick;
  assign conv_start_o = (st_nxt == SCC_CONV) && (st_r != SCC_CONV);
  assign ref_source_select_o = ref_r[SCC_REF_SEL_BIT];
  assign temp_sensor_enable_o = ref_r[SCC_TEMP_EN_BIT];
  assign bias_gen_enable_o = ref_r[SCC_BIAS_EN_BIT];
  assign conv_irq_o = done_r && ie_r;

  // ----------------------------------------------------------------
  // Result stream; a full FIFO drops the word, the register keeps it
  // ----------------------------------------------------------------
  scc_fifo #(
    .WIDTH(RES_W),
    .DEPTH(SCC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(busy_fall),
    .in_ready_o(),
    .in_data_i(conv_result_i),
    .out_valid_o(res_valid_o),
    .out_ready_i(res_ready_i),
    .out_data_o(res_data_o)
  );

endmodule

// File: rtl/scc_fifo.sv
`timescale 1ns/1ns
module scc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointers and level
  // ----------------------------------------------------------------
  assign in_ready_o = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next pointer values; wrap works for any depth
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage has no reset, it is only read when valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule

// File: rtl/scc_pkg.sv
package scc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SCC_REF_CTRL_ADDR = 8'hd1;
  localparam logic [7:0] SCC_REF_CTRL_RST = 8'h00;
  localparam logic [7:0] SCC_REF_CTRL_WMASK = 8'h0e;
  localparam int SCC_REF_SEL_BIT = 3;
  localparam int SCC_TEMP_EN_BIT = 2;
  localparam int SCC_BIAS_EN_BIT = 1;

  // Control, configuration and result bytes (offsets of this block)
  localparam logic [7:0] SCC_CTRL_ADDR = 8'he8;
  localparam logic [7:0] SCC_CFG_ADDR = 8'hbc;
  localparam logic [7:0] SCC_DATA_ADDR = 8'hbe;
  localparam logic [7:0] SCC_CTRL_RST = 8'h00;
  localparam logic [7:0] SCC_CFG_RST = 8'hf8;
  localparam int SCC_EN_BIT = 7;
  localparam int SCC_TM_BIT = 6;
  localparam int SCC_DONE_BIT = 5;
  localparam int SCC_BUSY_BIT = 4;
  localparam int SCC_IE_BIT = 3;
  localparam int SCC_SRC_LSB = 0;
  localparam int SCC_DIV_LSB = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SCC_DIV_W = 5;
  localparam int SCC_TRACK_CLKS = 3;
  localparam int SCC_CONV_CLKS = 9;
  localparam int SCC_FIFO_DEPTH = 16;

  // Start source codes
  typedef enum logic [2:0] {
    SCC_SRC_SW = 3'b000,
    SCC_SRC_T0 = 3'b001,
    SCC_SRC_T2 = 3'b010,
    SCC_SRC_T1 = 3'b011,
    SCC_SRC_EXT = 3'b100
  } scc_src_t;

  // Register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_sfr_req_t;

  // Start triggers from the timers
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_lo_ovf;
    logic t2_hi_ovf;
    logic t2_split;
  } scc_trig_t;

endpackage

// File: test/scc_conv_model.sv
`timescale 1ns/1ns
module scc_conv_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // From the control block
  input wire logic start_i,
  input wire logic sar_clk_i,
  // Bench knobs: latency in sar ticks and value to convert
  input wire logic [3:0] ticks_i,
  input wire logic [7:0] value_i,
  // Back to the control block
  output logic eoc_o,
  output logic [7:0] result_o
);
  logic busy_r;
  logic [3:0] cnt_r;

  // Counts sar ticks; result is held only in the end cycle and the one after, so a
  // sample more than one cycle late sees a toggling bus instead of a lucky old value
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      eoc_o <= 1'b0;
      result_o <= 8'h00;
    end else begin
      eoc_o <= 1'b0;
      if (start_i) begin
        busy_r <= 1'b1;
        cnt_r <= ticks_i;
      end else if (busy_r && sar_clk_i) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r <= 4'h1) begin
          busy_r <= 1'b0;
          eoc_o <= 1'b1;
          result_o <= value_i;
        end
      end else if (!eoc_o) begin
        result_o <= ~result_o;
      end
    end
  end
endmodule

// File: test/scc_ctrl_monitor.sv
`timescale 1ns/1ns
module scc_ctrl_monitor
  import scc_pkg::*;
#(
  parameter int DIV_W = 5,
  parameter int RES_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register access
  input wire scc_pkg::scc_sfr_req_t sfr_i,
  input wire logic [7:0] sfr_rdata_o,
  // Start triggers
  input wire scc_pkg::scc_trig_t trig_i,
  input wire logic ext_convert_start_i,
  // Analog converter
  input wire logic conv_track_o,
  input wire logic conv_sar_clk_o,
  input wire logic conv_start_o,
  input wire logic conv_eoc_i,
  input wire logic [RES_W-1:0] conv_result_i,
  input wire logic ref_source_select_o,
  input wire logic temp_sensor_enable_o,
  input wire logic bias_gen_enable_o,
  // Completion
  input wire logic conv_irq_o,
  input wire logic res_valid_o,
  input wire logic res_ready_i,
  input wire logic [RES_W-1:0] res_data_o
);
  // ------------------------------------------------
  // Properties, one clock domain only
  // ------------------------------------------------
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  irq_level_a:
  assert property (sfr_i.addr == SCC_CTRL_ADDR |-> conv_irq_o ==
    (sfr_rdata_o[SCC_DONE_BIT] & sfr_rdata_o[SCC_IE_BIT]))
    else $error("interrupt differs from done and enable");
  ref_unused_a:
  assert property (sfr_i.addr == SCC_REF_CTRL_ADDR |->
    (sfr_rdata_o & 8'hf1) == 8'h00)
    else $error("unused reference bits read nonzero");
  ref_pins_a:
  assert property (sfr_i.addr == SCC_REF_CTRL_ADDR |-> {ref_source_select_o,
    temp_sensor_enable_o, bias_gen_enable_o} == sfr_rdata_o[3:1])
    else $error("reference pins differ from register");
  ref_write_a:
  assert property (sfr_i.wr && sfr_i.addr == SCC_REF_CTRL_ADDR |=>
    ref_source_select_o == $past(sfr_i.wdata[3]) &&
    bias_gen_enable_o == $past(sfr_i.wdata[1]))
    else $error("reference write not taken");
  start_pulse_a:
  assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion restarted at once");
  track_hold_a:
  assert property (conv_start_o |=> !conv_track_o)
    else $error("still tracking while converting");
  fifo_hold_a:
  assert property (res_valid_o && !res_ready_i |=>
    res_valid_o && $stable(res_data_o))
    else $error("result word lost while stalled");
  fifo_pop_a:
  assert property ($fell(res_valid_o) |-> $past(res_ready_i))
    else $error("result word vanished without a pop");
endmodule

bind scc_ctrl scc_ctrl_monitor #(.DIV_W(DIV_W), .RES_W(RES_W))
  scc_ctrl_monitor_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_i(sfr_i),
  .sfr_rdata_o(sfr_rdata_o), .trig_i(trig_i),
  .ext_convert_start_i(ext_convert_start_i), .conv_track_o(conv_track_o),
  .conv_sar_clk_o(conv_sar_clk_o), .conv_start_o(conv_start_o),
  .conv_eoc_i(conv_eoc_i), .conv_result_i(conv_result_i),
  .ref_source_select_o(ref_source_select_o),
  .temp_sensor_enable_o(temp_sensor_enable_o),
  .bias_gen_enable_o(bias_gen_enable_o), .conv_irq_o(conv_irq_o),
  .res_valid_o(res_valid_o), .res_ready_i(res_ready_i),
  .res_data_o(res_data_o));

// File: test/tb_sar_conversion_control.sv
`timescale 1ns/1ns
module tb_sar_conversion_control;
  import scc_pkg::*;
  // ------------------------------------------------
  // Bench signals
  // ------------------------------------------------
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  scc_sfr_req_t sfr_i = '0;
  scc_trig_t trig_i = '0;
  logic ext_pin = 1'b0;
  logic [7:0] crossbar_skip_reg = 8'h00;
  logic res_ready = 1'b0;
  logic [3:0] ticks = 4'h3;
  logic [7:0] value = 8'h00;
  logic track, sar_clk, conv_start, eoc, irq, res_valid;
  logic ref_sel, temp_en, bias_en;
  logic [7:0] rdata, conv_res, res_data;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int tks = 0;
  int trk = 0;

  scc_ctrl #(.DIV_W(5), .RES_W(8)) scc_ctrl_inst (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .sfr_i(sfr_i), .sfr_rdata_o(rdata),
    .trig_i(trig_i), .ext_convert_start_i(ext_pin), .conv_track_o(track),
    .conv_sar_clk_o(sar_clk), .conv_start_o(conv_start), .conv_eoc_i(eoc),
    .conv_result_i(conv_res), .ref_source_select_o(ref_sel),
    .temp_sensor_enable_o(temp_en), .bias_gen_enable_o(bias_en),
    .conv_irq_o(irq), .res_valid_o(res_valid), .res_ready_i(res_ready),
    .res_data_o(res_data));
  scc_conv_model scc_conv_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .start_i(conv_start), .sar_clk_i(sar_clk), .ticks_i(ticks),
    .value_i(value), .eoc_o(eoc), .result_o(conv_res));

  always #20 clk_i = ~clk_i;

  // Sar ticks from a start request to the conversion phase; watchdog
  always @(posedge clk_i) begin
    cyc++;
    if (trk < 0 && sar_clk) tks++;
    if (trk < 0 && conv_start) trk = tks;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  function automatic logic [7:0] ref_exp(input logic [7:0] w);
    return {4'h0, w[3:1], 1'b0};
  endfunction

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_i = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    sfr_i.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_i.addr = a;
    #1 d = rdata;
  endtask

  // Decoy pulses only unselected sources, the wrong timer 2 byte among them
  task automatic fire(input logic [2:0] s, input logic [7:0] cw,
                      input logic ok);
    @(negedge clk_i);
    if (!ok) begin
      trig_i.t0_ovf = (s != SCC_SRC_T0);
      trig_i.t1_ovf = (s == SCC_SRC_T0);
      trig_i.t2_lo_ovf = !trig_i.t2_split;
      trig_i.t2_hi_ovf = trig_i.t2_split;
      ext_pin = (s != SCC_SRC_EXT);
    end else if (s == SCC_SRC_SW) begin
      sfr_i = '{1'b1, 1'b0, SCC_CTRL_ADDR, cw | 8'h10};
    end
    else if (s == SCC_SRC_T0) trig_i.t0_ovf = 1'b1;
    else if (s == SCC_SRC_T1) trig_i.t1_ovf = 1'b1;
    else if (s == SCC_SRC_T2) trig_i[2:1] = {trig_i.t2_split, !trig_i.t2_split};
    else ext_pin = crossbar_skip_reg[6];
    @(negedge clk_i);
    sfr_i.wr = 1'b0;
    trig_i[4:1] = 4'h0;
  endtask

  task automatic run(input logic [2:0] s, input logic tm, input logic ie,
                     input logic pop);
    logic [7:0] cw;
    logic [7:0] d;
    logic seen;
    int n;
    cw = {1'b1, tm, 2'b00, ie, s};
    value = 8'($urandom);
    ticks = 4'($urandom_range(8, 3));
    ext_pin = 1'b0;
    crossbar_skip_reg[6] = (s == SCC_SRC_EXT);
    wr(SCC_CTRL_ADDR, cw);
    fire(s, cw, 1'b0);
    // Idle gap settles the pin level and gives the input its tracking time
    repeat (6) @(negedge clk_i);
    if (!tm || s == SCC_SRC_EXT) chk(track, 1'b1);
    rd(SCC_CTRL_ADDR, d);
    chk(d[SCC_BUSY_BIT], 1'b0);
    tks = 0;
    trk = -1;
    fire(s, cw, 1'b1);
    fire(s, cw, 1'b1);
    seen = 1'b0;
    n = 0;
    do begin
      rd(SCC_CTRL_ADDR, d);
      seen |= (d[SCC_BUSY_BIT] === 1'b1);
      n++;
    end while (d[SCC_DONE_BIT] !== 1'b1 && n < 200);
    chk(d & 8'h30, 8'h20);
    chk(seen, 1'b1);
    chk(irq, ie);
    // Pin edge spends three clocks in the synchroniser, so up to 3 ticks
    if (tm && s != SCC_SRC_EXT) chk(trk >= 3, 1'b1);
    else chk(trk <= ((s == SCC_SRC_EXT) ? 3 : 1), 1'b1);
    rd(SCC_DATA_ADDR, d);
    chk(d, value);
    if (pop) begin
      chk(res_valid, 1'b1);
      chk(res_data, value);
      res_ready = 1'b1;
      @(negedge clk_i);
      res_ready = 1'b0;
      chk(res_valid, 1'b0);
    end
    wr(SCC_CTRL_ADDR, cw);
    chk(irq, 1'b0);
    $display("test source %0d low power %0d ended", s, tm);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] w;
    int g;
    int n;
    g = $urandom(46732);
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    rd(SCC_REF_CTRL_ADDR, d);
    chk(d, 8'h00);
    rd(SCC_CTRL_ADDR, d);
    chk(d, 8'h00);
    rd(SCC_CFG_ADDR, d);
    chk(d, 8'hf8);
    rd(8'h80, d);
    chk(d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'hff : 8'($urandom);
      wr(SCC_REF_CTRL_ADDR, w);
      rd(SCC_REF_CTRL_ADDR, d);
      chk(d, ref_exp(w));
      chk({5'h00, ref_sel, temp_en, bias_en}, {5'h00, w[3:1]});
    end
    $display("test reference control ended");
    // Divider corners 0 and 31, then random ones
    for (int i = 0; i < 4; i++) begin
      g = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(30, 1);
      wr(SCC_CFG_ADDR, {g[4:0], 3'b000});
      wr(SCC_CTRL_ADDR, 8'h80);
      n = 0;
      while (sar_clk !== 1'b1 && n < 99) begin
        @(negedge clk_i);
        n++;
      end
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (sar_clk !== 1'b1 && n < 99);
      chk(8'(n), 8'(g + 1));
      wr(SCC_CTRL_ADDR, 8'h00);
    end
    $display("test divider ended");
    wr(SCC_CFG_ADDR, 8'h08);
    // Bias generator must be running before any conversion
    wr(SCC_REF_CTRL_ADDR, 8'h02);
    chk(bias_en, 1'b1);
    for (int i = 0; i < 10; i++) begin
      trig_i.t2_split = i[0];
      run(3'(i % 5), i >= 5, 1'($urandom), 1'b1);
    end
    for (int i = 0; i < 6; i++)
      run(3'($urandom_range(4, 0)), 1'($urandom), 1'($urandom), 1'b1);
    // Far side stalls until the buffer overflows, then drains it
    repeat (17) run(SCC_SRC_SW, 1'b0, 1'b0, 1'b0);
    @(negedge clk_i);
    res_ready = 1'b1;
    n = 0;
    while (res_valid === 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    res_ready = 1'b0;
    chk(8'(n), 8'h10);
    $display("test buffer ended");
    print_verdict();
  end
endmodule
